// ---- twd_cfg.svh ----
// Constants of the two-wire debug register access port
`ifndef TWD_CFG_SVH
`define TWD_CFG_SVH

// Target-select codes that steer data read and data write commands
`define TWD_SEL_PART_ID 8'h00
`define TWD_SEL_REVISION 8'h01
`define TWD_SEL_FLASH_CTRL 8'h02
`define TWD_SEL_FLASH_DATA 8'hB4

// Link addresses of the identification registers, also the mirror addresses
`define TWD_ADDR_PART_ID 8'hFD
`define TWD_ADDR_REVISION 8'hFE
`define TWD_ID_PAGE 8'h0F

// Reset values
`define TWD_TSEL_RESET 8'h00
`define TWD_FLASH_CTRL_RESET 8'h00
`define TWD_FLASH_DATA_RESET 8'h00
`define TWD_WORD_RESET 8'h00

// Instruction codes, sent first bit first after the start bit
`define TWD_INS_DATA_READ 2'h0
`define TWD_INS_DATA_WRITE 2'h1
`define TWD_INS_ADDR_READ 2'h2
`define TWD_INS_ADDR_WRITE 2'h3

// Bit counts of a frame: last index of the instruction and write phases, bit total of the read phase
`define TWD_INSTR_LAST 4'h1
`define TWD_DATA_LAST 4'h7
`define TWD_READ_BITS 4'h8

`endif

// ---- twd_pkg.sv ----
// Types of the two-wire debug register access port
package twd_pkg;

    // Phases of a frame on the link side
    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_INSTR,
        LINK_WDATA,
        LINK_RWAIT,
        LINK_RDATA
    } twd_link_state_t;

    // One request handed from the link side to the core side
    typedef struct packed {
        logic [1:0] instr; // Instruction code
        logic [7:0] data; // Write payload, zero for reads
    } twd_req_t;

    // All state clocked by the debug clock line
    typedef struct packed {
        logic rst_s1; // Reset synchroniser, first stage
        logic rst_s2; // Reset synchroniser, second stage
        twd_link_state_t state; // Frame phase
        logic [3:0] cnt; // Bit counter within a phase
        logic [1:0] instr; // Instruction being received
        logic [7:0] shift; // Data shift register
        twd_req_t req; // Request word held for the core
        logic req_tog; // Toggles once per request
        logic ack_s1; // Answer toggle, first stage
        logic ack_s2; // Answer toggle, second stage
        logic dout; // Data line output level
        logic doe; // Data line output enable
    } twd_link_st_t;

    // All state clocked by the main clock
    typedef struct packed {
        logic req_s1; // Request toggle, first stage
        logic req_s2; // Request toggle, second stage
        logic req_seen; // Last request toggle served
        logic ack_tog; // Toggles once per served request
        logic [7:0] tsel; // Target-select register
        logic [7:0] fctrl; // Flash programming control
        logic [7:0] fdata; // Flash programming data
        logic fctrl_stb; // Control written this cycle
        logic fdata_stb; // Data written this cycle
        logic [7:0] rdword; // Answer word for reads
        logic [7:0] rev_s1; // Revision strap, first stage
        logic [7:0] rev_s2; // Revision strap, second stage
    } twd_core_st_t;

endpackage : twd_pkg

// ---- twd_port.sv ----
// Two-wire debug port: link framing, target selection and flash registers
`timescale 1ns/1ps
`include "twd_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RQ1: Host clock line plus shared bidirectional data line
// RQ2: Eight-bit target select, reset zero, host written
// RQ3: Select 00 reads the part identifier
// RQ4: Select 01 reads the silicon revision
// RQ5: Select 02 reaches flash control register
// RQ6: Select B4 reaches flash data register
// RQ7: Fixed read-only part identifier, also mirrored; the port has no mirror, only select 00 reads it
// RQ8: Read-only silicon revision from silicon straps
// RQ9: Writes to identification registers change nothing
module twd_port #(
    parameter logic [7:0] PART_ID = 8'h5A // Arbitrary value, not a real code
) (
    input wire logic MCLK, // Main clock, 50 MHz
    input wire logic SYS_RST, // Synchronous reset, active high
    input wire logic DEBUG_CLOCK_LINE, // Link clock driven by the host
    input wire logic DEBUG_DATA_LINE_I, // Data line level seen at the pin
    output logic DEBUG_DATA_LINE_O, // Data line level driven by us
    output logic DEBUG_DATA_LINE_OE, // High while we drive the data line
    input wire logic [7:0] SILICON_REV_PINS, // Revision straps of the die
    output logic [7:0] FLASH_CTRL, // Flash programming control register
    output logic [7:0] FLASH_DATA, // Flash programming data register
    output logic FLASH_CTRL_STB, // One-cycle pulse on control write
    output logic FLASH_DATA_STB // One-cycle pulse on data write
);

    ////////////////////////////////////////////////////////////////////////////
    // State of both domains
    twd_pkg::twd_link_st_t l; // Link-side state
    twd_pkg::twd_link_st_t next_l; // Link-side next state
    twd_pkg::twd_core_st_t c; // Core-side state
    twd_pkg::twd_core_st_t next_c; // Core-side next state

    // Read answer for the current target; unknown targets read zero
    function automatic logic [7:0] read_mux(input logic [7:0] sel,
                                            input logic [7:0] rev,
                                            input logic [7:0] fctrl,
                                            input logic [7:0] fdata);
        logic [7:0] val;
        val = `TWD_WORD_RESET;
        unique case (sel)
            `TWD_SEL_PART_ID: val = PART_ID; // RQ3 RQ7
            `TWD_SEL_REVISION: val = rev; // RQ4 RQ8
            `TWD_SEL_FLASH_CTRL: val = fctrl; // RQ5
            `TWD_SEL_FLASH_DATA: val = fdata; // RQ6
            default: val = `TWD_WORD_RESET;
        endcase
        return val;
    endfunction : read_mux

    ////////////////////////////////////////////////////////////////////////////
    // Link side: frames are a low start bit, two instruction bits, then either
    // eight write bits or a wait phase and eight read bits; data LSB first, instruction MSB first.
    // The host clock may stop between frames; only the link reset relies on
    // edges outside a frame.
    always_comb begin
        next_l = l;
        next_l.rst_s1 = SYS_RST;
        next_l.rst_s2 = l.rst_s1;
        next_l.ack_s1 = c.ack_tog;
        next_l.ack_s2 = l.ack_s1;
        if (l.rst_s2) begin
            // Host must clock the link during reset for this to take
            next_l.state = twd_pkg::LINK_IDLE;
            next_l.cnt = 4'h0;
            next_l.instr = 2'h0;
            next_l.shift = `TWD_WORD_RESET;
            next_l.req = '0;
            next_l.req_tog = 1'b0;
            next_l.dout = 1'b0;
            next_l.doe = 1'b0;
        end else begin
            unique case (l.state)
                twd_pkg::LINK_IDLE: begin
                    next_l.doe = 1'b0; // Line belongs to the host
                    if (!DEBUG_DATA_LINE_I) begin
                        next_l.state = twd_pkg::LINK_INSTR; // Start bit seen
                        next_l.cnt = 4'h0;
                    end
                end
                twd_pkg::LINK_INSTR: begin
                    next_l.instr = {l.instr[0], DEBUG_DATA_LINE_I}; // RQ1
                    next_l.cnt = l.cnt + 4'h1;
                    if (l.cnt == `TWD_INSTR_LAST) begin
                        next_l.cnt = 4'h0;
                        if (next_l.instr[0]) begin
                            next_l.state = twd_pkg::LINK_WDATA;
                        end else begin
                            // Reads ask the core at once and then hold low
                            next_l.req.instr = next_l.instr;
                            next_l.req.data = `TWD_WORD_RESET;
                            next_l.req_tog = ~l.req_tog;
                            next_l.state = twd_pkg::LINK_RWAIT;
                            next_l.dout = 1'b0;
                            next_l.doe = 1'b1; // RQ1
                        end
                    end
                end
                twd_pkg::LINK_WDATA: begin
                    next_l.shift = {DEBUG_DATA_LINE_I, l.shift[7:1]};
                    next_l.cnt = l.cnt + 4'h1;
                    if (l.cnt == `TWD_DATA_LAST) begin
                        // Word is held until the next frame, past the handshake
                        next_l.req.instr = l.instr;
                        next_l.req.data = next_l.shift;
                        next_l.req_tog = ~l.req_tog;
                        next_l.state = twd_pkg::LINK_IDLE;
                    end
                end
                twd_pkg::LINK_RWAIT: begin
                    next_l.dout = 1'b0; // Still busy
                    if (l.ack_s2 == l.req_tog) begin
                        // Answer word is stable once the toggle is back
                        next_l.shift = c.rdword;
                        next_l.dout = 1'b1; // Ready marker
                        next_l.cnt = 4'h0;
                        next_l.state = twd_pkg::LINK_RDATA;
                    end
                end
                twd_pkg::LINK_RDATA: begin
                    if (l.cnt == `TWD_READ_BITS) begin
                        next_l.doe = 1'b0; // Hand the line back
                        next_l.state = twd_pkg::LINK_IDLE;
                    end else begin
                        next_l.dout = l.shift[0]; // RQ1
                        next_l.shift = {1'b0, l.shift[7:1]};
                        next_l.cnt = l.cnt + 4'h1;
                    end
                end
                default: begin
                    // Illegal phase code: drop the line and wait for a start bit
                    next_l.doe = 1'b0;
                    next_l.state = twd_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    // Link-side register
    always_ff @(posedge DEBUG_CLOCK_LINE) begin
        l <= next_l;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core side: serves one request per toggle of the link, in order
    always_comb begin
        next_c = c;
        next_c.req_s1 = l.req_tog;
        next_c.req_s2 = c.req_s1;
        next_c.rev_s1 = SILICON_REV_PINS;
        next_c.rev_s2 = c.rev_s1;
        next_c.fctrl_stb = 1'b0;
        next_c.fdata_stb = 1'b0;
        if (SYS_RST) begin
            next_c.req_seen = c.req_s2;
            next_c.ack_tog = c.req_s2;
            next_c.tsel = `TWD_TSEL_RESET; // RQ2
            next_c.fctrl = `TWD_FLASH_CTRL_RESET;
            next_c.fdata = `TWD_FLASH_DATA_RESET;
            next_c.rdword = `TWD_WORD_RESET;
        end else if (c.req_s2 != c.req_seen) begin
            next_c.req_seen = c.req_s2;
            next_c.ack_tog = c.req_s2; // Answer ready, echo the toggle
            unique case (l.req.instr)
                `TWD_INS_ADDR_WRITE: next_c.tsel = l.req.data; // RQ2
                `TWD_INS_ADDR_READ: next_c.rdword = c.tsel; // RQ2
                `TWD_INS_DATA_WRITE: begin
                    // Identification targets ignore writes
                    if (c.tsel == `TWD_SEL_FLASH_CTRL) begin
                        next_c.fctrl = l.req.data; // RQ5
                        next_c.fctrl_stb = 1'b1;
                    end else if (c.tsel == `TWD_SEL_FLASH_DATA) begin
                        next_c.fdata = l.req.data; // RQ6
                        next_c.fdata_stb = 1'b1;
                    end // RQ9
                end
                `TWD_INS_DATA_READ: begin
                    next_c.rdword = read_mux(c.tsel, c.rev_s2, c.fctrl, c.fdata);
                end
            endcase
        end
    end

    // Core-side register
    always_ff @(posedge MCLK) begin
        c <= next_c;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign DEBUG_DATA_LINE_O = l.dout;
    assign DEBUG_DATA_LINE_OE = l.doe;
    assign FLASH_CTRL = c.fctrl;
    assign FLASH_DATA = c.fdata;
    assign FLASH_CTRL_STB = c.fctrl_stb;
    assign FLASH_DATA_STB = c.fdata_stb;

endmodule : twd_port

// ---- twd_port_properties.sv ----
// Port checks for the two-wire debug port
`timescale 1ns/1ps
module twd_port_properties (
    input wire logic MCLK, // Main clock
    input wire logic SYS_RST, // Reset
    input wire logic DEBUG_CLOCK_LINE, // Link clock
    input wire logic DEBUG_DATA_LINE_I, // Resolved line
    input wire logic DEBUG_DATA_LINE_O, // Driven level
    input wire logic DEBUG_DATA_LINE_OE, // Drive enable
    input wire logic [7:0] SILICON_REV_PINS, // Straps
    input wire logic [7:0] FLASH_CTRL, // Control register
    input wire logic [7:0] FLASH_DATA, // Data register
    input wire logic FLASH_CTRL_STB, // Control strobe
    input wire logic FLASH_DATA_STB // Data strobe
);
    ////////////////////////////////////////////////////////////
    // Main clock side: strobes are single pulses, registers move only with them
    ctrl_pulse_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        FLASH_CTRL_STB |=> !FLASH_CTRL_STB) else $error("control strobe long");
    data_pulse_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        FLASH_DATA_STB |=> !FLASH_DATA_STB) else $error("data strobe long");
    ctrl_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !FLASH_CTRL_STB |-> $stable(FLASH_CTRL)) else $error("control moved");
    data_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !FLASH_DATA_STB |-> $stable(FLASH_DATA)) else $error("data moved");
    reset_clear_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $past(SYS_RST) |-> FLASH_CTRL == 8'h00 && FLASH_DATA == 8'h00 && !FLASH_CTRL_STB)
        else $error("reset value wrong");
    // Link side: busy level first, bounded wait for the marker, full answer
    busy_first_a: assert property (@(posedge DEBUG_CLOCK_LINE) disable iff (SYS_RST)
        $rose(DEBUG_DATA_LINE_OE) |-> !DEBUG_DATA_LINE_O) else $error("no busy level");
    marker_bound_a: assert property (@(posedge DEBUG_CLOCK_LINE) disable iff (SYS_RST)
        $rose(DEBUG_DATA_LINE_OE) |-> ##[1:12] DEBUG_DATA_LINE_O) else $error("no marker");
    line_release_a: assert property (@(posedge DEBUG_CLOCK_LINE) disable iff (SYS_RST)
        $fell(DEBUG_DATA_LINE_OE) |-> $past(DEBUG_DATA_LINE_OE, 9)) else $error("answer short");
endmodule : twd_port_properties

bind twd_port twd_port_properties twd_port_properties_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .DEBUG_CLOCK_LINE(DEBUG_CLOCK_LINE), .DEBUG_DATA_LINE_I(DEBUG_DATA_LINE_I),
    .DEBUG_DATA_LINE_O(DEBUG_DATA_LINE_O), .DEBUG_DATA_LINE_OE(DEBUG_DATA_LINE_OE),
    .SILICON_REV_PINS(SILICON_REV_PINS), .FLASH_CTRL(FLASH_CTRL), .FLASH_DATA(FLASH_DATA),
    .FLASH_CTRL_STB(FLASH_CTRL_STB), .FLASH_DATA_STB(FLASH_DATA_STB));

// ---- twd_host_model.sv ----
// Behavioural debug host: link clock, shared data line and frame tasks
`timescale 1ns/1ps
module twd_host_model (
    output logic link_clk, // Link clock, still between frames
    output logic line, // Resolved data line
    input wire logic dev_o, // Device data level
    input wire logic dev_oe // Device drive enable
);
    logic hv = 1'b1, hoe = 1'b1, lastv = 1'b1, smp; // Host level, host drive, history, sample
    logic [7:0] rd_byte; // Byte of the last read
    event rd_done; // Read frame finished
    ////////////////////////////////////////////////////////////
    // No pull on the line: released, it shows the inverse of its last level
    assign line = dev_oe ? dev_o : (hoe ? hv : ~lastv);
    initial link_clk = 1'b0;
    // One link cycle; data changes at the fall, the line is sampled at the rise
    task automatic tick();
        #24 smp = line;
        lastv = smp;
        link_clk = 1'b1;
        #24 link_clk = 1'b0;
    endtask : tick
    task automatic idle(input int n);
        hv = 1'b1; // Idle level, set once before the clock runs
        repeat (n) tick();
    endtask : idle
    // Start bit, instruction first bit first, write data LSB first
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd);
        logic [10:0] bits;
        int n;
        bits = {wd, ins[0], ins[1], 1'b0};
        for (n = 0; n < (ins[0] ? 11 : 3); n++) begin
            hv = bits[n];
            tick();
        end
        // Level stays put so a following start bit is the only change here
        if (ins[0])
            return;
        hoe = 1'b0; // Hand the line over for the answer
        rd_byte = 8'hXX;
        for (n = 0; n < 12 && smp !== 1'b1; n++)
            tick();
        if (smp === 1'b1) begin
            for (n = 0; n < 8; n++) begin
                tick();
                rd_byte[n] = smp;
            end
        end
        hoe = 1'b1;
        -> rd_done;
    endtask : frame
endmodule : twd_host_model

// ---- two_wire_debug_register_access_bench.sv ----
// Self-checking bench of the two-wire debug port
`timescale 1ns/1ps
`include "twd_cfg.svh"
module two_wire_debug_register_access_bench;
    localparam logic [7:0] PART_ID = 8'h6B; // Arbitrary identity value
    logic mclk = 1'b0, sys_rst = 1'b1, lclk, line, dout, doe, cstb, dstb;
    logic [7:0] rev_pins = 8'h00, fctrl, fdata, v, rev_v, sel;
    logic [7:0] exp_rd[$]; // Noted read bytes
    logic [8:0] exp_wr[$]; // Noted writes, top bit marks the data register
    int err_total = 0, checks_done = 0, cycles = 0;
    always #10 mclk = ~mclk;
    twd_port #(.PART_ID(PART_ID)) twd_port_i (.MCLK(mclk), .SYS_RST(sys_rst),
        .DEBUG_CLOCK_LINE(lclk), .DEBUG_DATA_LINE_I(line), .DEBUG_DATA_LINE_O(dout),
        .DEBUG_DATA_LINE_OE(doe), .SILICON_REV_PINS(rev_pins), .FLASH_CTRL(fctrl),
        .FLASH_DATA(fdata), .FLASH_CTRL_STB(cstb), .FLASH_DATA_STB(dstb));
    twd_host_model twd_host_model_i (.link_clk(lclk), .line(line), .dev_o(dout), .dev_oe(doe));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        checks_done++;
        err_total += int'(!ok);
        if (!ok)
            $display("[FAIL] %0t %s", $time, msg);
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // Reads note their byte before the frame goes out
    task automatic xfer(input logic [1:0] ins, input logic [7:0] d);
        if (!ins[0])
            exp_rd.push_back(d);
        twd_host_model_i.frame(ins, d);
    endtask : xfer
    // Each returned byte against the oldest note
    always @(twd_host_model_i.rd_done)
        check(twd_host_model_i.rd_byte === exp_rd.pop_front(), "read");
    // Hang guard, and every strobe must match a noted write
    always @(posedge mclk) begin
        cycles++;
        if (cstb === 1'b1 || dstb === 1'b1) begin
            check(exp_wr.size() > 0 && exp_wr[0] === {dstb, dstb ? fdata : fctrl}, "write");
            if (exp_wr.size() > 0)
                exp_wr.delete(0);
        end
        if (cycles == 3000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        v = 8'($urandom(32'h9107));
        rev_v = 8'($urandom);
        twd_host_model_i.idle(3); // Link must see the reset too
        // Core must copy the settled link toggle before reset lets go
        repeat (3) @(posedge mclk);
        @(posedge mclk);
        sys_rst <= 1'b0;
        rev_pins <= rev_v;
        twd_host_model_i.idle(4);
        xfer(`TWD_INS_ADDR_READ, `TWD_TSEL_RESET);
        xfer(`TWD_INS_DATA_READ, PART_ID);
        $display("reset test done");
        // The four defined select codes and unknown code 55: set, read back, write, read
        for (int i = 0; i < 5; i++) begin
            sel = (i == 0) ? `TWD_SEL_FLASH_CTRL : (i == 1) ? `TWD_SEL_FLASH_DATA
                : (i == 2) ? `TWD_SEL_PART_ID : (i == 3) ? `TWD_SEL_REVISION : 8'h55;
            v = 8'($urandom);
            xfer(`TWD_INS_ADDR_WRITE, sel);
            xfer(`TWD_INS_ADDR_READ, sel);
            if (i < 2)
                exp_wr.push_back({i[0], v});
            xfer(`TWD_INS_DATA_WRITE, v);
            xfer(`TWD_INS_DATA_READ, (i < 2) ? v : (i == 2) ? PART_ID
                : (i == 3) ? rev_v : `TWD_WORD_RESET);
            $display("select test %0d done", i);
        end
        repeat (20) @(posedge mclk);
        check(exp_wr.size() == 0 && exp_rd.size() == 0, "result missing");
        complete_run();
    end
endmodule : two_wire_debug_register_access_bench
